// >>> hdl/aacc_top.sv
// aux converter conversion control, mux routing and output coding
`timescale 1ns/100ps
// What this block does
// - current codes clip at full-scale limits
// - current codes are two's complement
// - per-step positive and negative input select
// - positive select offers external and internal sources
// - negative is ground or eighth input
// - internal source disconnects inputs, forces ground
// - per-step gain of one, two or four
// - unipolar results stay in positive code range
// - modulator clocked at half main clock
// - aux conversions only single-shot, sequencer-started
// - filter cleared at start, settled results only
// - oversampling select gives 64 to 512
// - ratio 64: sinc3, 384 cycles
// - higher ratios add sinc1 by 2, 4, 8
// - both current results delivered, 24 bits
module aacc_top (
   input wire logic clk, // main clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic stepStart, // sequencer starts a step
   input wire aacc_pkg::aacc_step_t stepCfg, // step selects
   output logic stepReady, // a step may start
   input wire logic modBitPin, // modulator bitstream pin
   output logic modClkOut, // modulator clock, clk/2
   output aacc_pkg::aacc_route_t route, // mux and gain setting
   output logic resultStrobe, // one-cycle result done
   output logic [15:0] resData, // buffered aux result
   output logic resValid, // buffered result waiting
   input wire logic resReady, // reader takes result
   input wire logic curValid, // current filter words valid
   input wire aacc_pkg::aacc_cur_t curRaw, // unclipped current words
   output logic [23:0] curCodeA, // current code, channel a
   output logic [23:0] curCodeB, // current code, channel b
   output logic curCodeValid // current codes updated
);
   import aacc_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_PUSH = 2'b10
   } aacc_state_t;

   logic [1:0] rstSh_r;
   logic nrstSync;
   logic modSync1_r, modSync2_r;
   aacc_state_t state_r, state_nxt;
   logic [11:0] cnt_r, convLen_r;
   logic [1:0] convOsr_r, osrSel_r;
   logic convUni_r, unipolar_r, cfgErr_r;
   logic signed [19:0] int1_r, int2_r, int3_r;
   logic signed [19:0] dly1_r, dly2_r, dly3_r;
   logic signed [19:0] comb1, comb2, comb3;
   logic signed [22:0] acc_r, accFinal, scaled;
   logic [15:0] result_r, resCode;
   logic startOk, modSample, winEdge, winSettled, convEnd;
   logic bufInReady;
   logic [1:0] bufLevel;
   logic apbWrite, apbRead, addrHit;
   aacc_route_t routeNew;

   // the whole design leaves reset on a synchronised edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         rstSh_r <= 2'b00;
      else
         rstSh_r <= {rstSh_r[0], 1'b1};
   end
   assign nrstSync = rstSh_r[1];

   // bitstream comes from the analog side, so it is synchronised first
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         modSync1_r <= 1'b0;
         modSync2_r <= 1'b0;
      end else begin
         modSync1_r <= modBitPin;
         modSync2_r <= modSync1_r;
      end
   end

   // mux routing from one step's selects
   function automatic aacc_route_t routeStep(input aacc_step_t s);
      aacc_route_t r;
      r = '0;
      r.pos = s.posSel;
      r.gain = s.gainSel;
      r.err = 1'b0;
      r.extConnect = 1'b1;
      r.negIn7 = s.negSel;
      // eighth input as negative excludes it as positive
      if (s.negSel == NEG_IN7 && s.posSel == POS_EXT_LAST) begin
         r.err = 1'b1;
         r.pos = POS_SHORT;
      end
      // internal sources drop inputs, ground negative
      if (r.pos > POS_EXT_LAST) begin
         r.extConnect = 1'b0;
         r.negIn7 = NEG_GROUND;
      end
      // gain one, two, four; reserved code falls back to one
      if (s.gainSel != GAIN_X1 && s.gainSel != GAIN_X2 &&
          s.gainSel != GAIN_X4) begin
         r.gain = GAIN_X1;
         r.err = 1'b1;
      end
      return r;
   endfunction
   assign routeNew = routeStep(stepCfg);

   // a conversion only starts on a sequencer strobe
   assign stepReady = (state_r == ST_IDLE) && bufInReady;
   assign startOk = stepStart && stepReady;

   // one modulator period is two clocks, sampled on the second
   assign modSample = (state_r == ST_CONV) && cnt_r[0] &&
                      (cnt_r < convLen_r);
   assign winEdge = (state_r == ST_CONV) && (cnt_r[WIN_LSB-1:0] == '0) &&
                    (cnt_r != '0);
   // only windows after sinc3 has settled feed the sinc1 sum
   assign winSettled = (cnt_r[11:WIN_LSB] >= (12-WIN_LSB)'(SINC3_SETTLE));
   // length from the latched oversampling select
   assign convEnd = (state_r == ST_CONV) && (cnt_r == convLen_r);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (startOk)
               state_nxt = ST_CONV;
         end
         ST_CONV: begin
            if (convEnd)
               state_nxt = ST_PUSH;
         end
         ST_PUSH: begin
            if (bufInReady)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // per-conversion settings are frozen at the start strobe
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         cnt_r <= 12'h000;
         convLen_r <= CONV_OSR64;
         convOsr_r <= CTRL_OSR_RST;
         convUni_r <= CTRL_UNIPOLAR_RST;
         route <= '0;
         cfgErr_r <= 1'b0;
      end else if (startOk) begin
         cnt_r <= 12'h000;
         convLen_r <= convCycles(osrSel_r);
         convOsr_r <= osrSel_r;
         convUni_r <= unipolar_r;
         route <= routeNew;
         cfgErr_r <= routeNew.err;
      end else if (state_r == ST_CONV) begin
         cnt_r <= cnt_r + 12'h001;
      end
   end

   // modulator clock runs only while converting
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync)
         modClkOut <= 1'b0;
      else
         modClkOut <= (state_nxt == ST_CONV) && !modClkOut;
   end

   assign comb1 = int3_r - dly1_r;
   assign comb2 = comb1 - dly2_r;
   assign comb3 = comb2 - dly3_r;
   assign accFinal = acc_r + (winSettled ? 23'(comb3) : 23'sd0);

   // integrators and combs cleared at every start
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         int1_r <= '0;
         int2_r <= '0;
         int3_r <= '0;
      end else if (startOk) begin
         int1_r <= '0;
         int2_r <= '0;
         int3_r <= '0;
      end else if (modSample) begin
         // wrap-around integrators are exact because the combs undo it
         int1_r <= int1_r + (modSync2_r ? 20'sd1 : -20'sd1);
         int2_r <= int2_r + int1_r;
         int3_r <= int3_r + int2_r;
      end
   end

   // sinc3 comb section, one output per 64 modulator samples
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         dly1_r <= '0;
         dly2_r <= '0;
         dly3_r <= '0;
         acc_r <= '0;
      end else if (startOk) begin
         dly1_r <= '0;
         dly2_r <= '0;
         dly3_r <= '0;
         acc_r <= '0;
      end else if (winEdge) begin
         dly1_r <= int3_r;
         dly2_r <= comb1;
         dly3_r <= comb2;
         // sinc1 sums the settled sinc3 outputs
         acc_r <= accFinal;
      end
   end

   // gain of sinc3 and sinc1 is removed so full scale maps to 16 bits
   assign scaled = accFinal >>> (SINC3_GAIN_LOG2 - AUX_BITS + 1 + convOsr_r);

   always_comb begin
      if (scaled > $signed(23'(AUX_MAX)))
         resCode = AUX_MAX;
      else if (scaled < -$signed(23'(AUX_MAX)) - 23'sd1)
         resCode = AUX_MIN;
      else
         resCode = scaled[15:0];
      // unipolar results never go below zero
      if (convUni_r && resCode[15])
         resCode = AUX_ZERO;
   end

   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync)
         result_r <= AUX_ZERO;
      else if (convEnd)
         result_r <= resCode;
   end

   // strobe marks the push; next step waits for the idle state
   assign resultStrobe = (state_r == ST_PUSH) && bufInReady;

   aacc_buf #(
      .WIDTH(AUX_BITS),
      .DEPTH(BUF_DEPTH)
   ) resBuf (
      .clk(clk),
      .nrstSync(nrstSync),
      .inValid(state_r == ST_PUSH),
      .inReady(bufInReady),
      .inData(result_r),
      .outValid(resValid),
      .outReady(resReady),
      .outData(resData),
      .level(bufLevel)
   );

   // current words clipped to 24-bit two's complement
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         curCodeA <= 24'h00_0000;
         curCodeB <= 24'h00_0000;
         curCodeValid <= 1'b0;
      end else begin
         curCodeValid <= curValid;
         if (curValid) begin
            curCodeA <= sat24(curRaw.rawA);
            curCodeB <= sat24(curRaw.rawB);
         end
      end
   end

   // apb slave: no wait states, unmapped addresses answer with error
   assign pready = 1'b1;
   assign apbWrite = psel && penable && pwrite;
   assign apbRead = psel && !pwrite;
   always_comb begin
      unique case (paddr)
         REG_CTRL, REG_STATUS, REG_RESULT, REG_CUR_A, REG_CUR_B:
            addrHit = 1'b1;
         default: addrHit = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addrHit;

   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         osrSel_r <= CTRL_OSR_RST;
         unipolar_r <= CTRL_UNIPOLAR_RST;
      end else if (apbWrite && paddr == REG_CTRL) begin
         osrSel_r <= pwdata[CTRL_OSR_LSB +: 2];
         unipolar_r <= pwdata[CTRL_UNIPOLAR];
      end
   end

   // read data is registered during setup so it is stable in access
   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         prdata <= 32'h0000_0000;
      end else if (apbRead && !penable) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            REG_CTRL: begin
               prdata[CTRL_OSR_LSB +: 2] <= osrSel_r;
               prdata[CTRL_UNIPOLAR] <= unipolar_r;
            end
            REG_STATUS: begin
               prdata[STAT_BUSY] <= (state_r != ST_IDLE);
               prdata[STAT_CFGERR] <= cfgErr_r;
               prdata[STAT_LEVEL_LSB +: 2] <= bufLevel;
            end
            REG_RESULT: prdata[15:0] <= result_r;
            REG_CUR_A: prdata[23:0] <= curCodeA;
            REG_CUR_B: prdata[23:0] <= curCodeB;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// >>> include/aacc_pkg.sv
// constants, types and helpers shared by the aux converter control
package aacc_pkg;
   // register byte offsets on the apb slave
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_STATUS = 12'h004;
   localparam logic [11:0] REG_RESULT = 12'h008;
   localparam logic [11:0] REG_CUR_A = 12'h00C;
   localparam logic [11:0] REG_CUR_B = 12'h010;
   // control register fields
   localparam int CTRL_OSR_LSB = 0;
   localparam int CTRL_UNIPOLAR = 2;
   localparam logic [1:0] CTRL_OSR_RST = 2'h0;
   localparam logic CTRL_UNIPOLAR_RST = 1'b0;
   // status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_CFGERR = 1;
   localparam int STAT_LEVEL_LSB = 4;
   // positive input select codes
   localparam logic [3:0] POS_EXT_LAST = 4'h7;
   localparam logic [3:0] POS_TEMP = 4'h8;
   localparam logic [3:0] POS_SHORT = 4'h9;
   localparam logic [3:0] POS_TESTDAC = 4'hA;
   // codes 4'hB to 4'hF pick attenuated supply rails
   localparam logic NEG_GROUND = 1'b0;
   localparam logic NEG_IN7 = 1'b1;
   // gain select codes
   localparam logic [1:0] GAIN_X1 = 2'h0;
   localparam logic [1:0] GAIN_X2 = 2'h1;
   localparam logic [1:0] GAIN_X4 = 2'h2;
   // timing: modulator runs at clk/2, sinc3 decimates by 64
   localparam int MOD_DIV = 2;
   localparam int SINC3_DEC = 64;
   localparam int WIN_CYC = MOD_DIV * SINC3_DEC;
   localparam int WIN_LSB = $clog2(WIN_CYC);
   localparam int SINC3_SETTLE = 3;
   localparam int SINC3_GAIN_LOG2 = 18;
   localparam int AUX_BITS = 16;
   localparam int CUR_BITS = 24;
   localparam int BUF_DEPTH = 2;
   // conversion lengths in main clock cycles
   localparam logic [11:0] CONV_OSR64 = 12'h180;
   localparam logic [11:0] CONV_OSR128 = 12'h200;
   localparam logic [11:0] CONV_OSR256 = 12'h300;
   localparam logic [11:0] CONV_OSR512 = 12'h500;
   localparam logic [15:0] AUX_MAX = 16'h7FFF;
   localparam logic [15:0] AUX_MIN = 16'h8000;
   localparam logic [15:0] AUX_ZERO = 16'h0000;
   localparam logic [23:0] CUR_MAX = 24'h7F_FFFF;
   localparam logic [23:0] CUR_MIN = 24'h80_0000;

   typedef struct packed {
      logic [3:0] posSel;
      logic negSel;
      logic [1:0] gainSel;
   } aacc_step_t;

   typedef struct packed {
      logic [3:0] pos;
      logic negIn7;
      logic extConnect;
      logic [1:0] gain;
      logic err;
   } aacc_route_t;

   typedef struct packed {
      logic signed [31:0] rawA;
      logic signed [31:0] rawB;
   } aacc_cur_t;

   function automatic logic [11:0] convCycles(input logic [1:0] osr);
      case (osr)
         2'h0: convCycles = CONV_OSR64;
         2'h1: convCycles = CONV_OSR128;
         2'h2: convCycles = CONV_OSR256;
         default: convCycles = CONV_OSR512;
      endcase
   endfunction

   function automatic logic [23:0] sat24(input logic signed [31:0] v);
      if (v > $signed({8'h00, CUR_MAX}))
         sat24 = CUR_MAX;
      else if (v < $signed({8'hFF, CUR_MIN}))
         sat24 = CUR_MIN;
      else
         sat24 = v[23:0];
   endfunction
endpackage

// >>> hdl/aacc_buf.sv
// small valid/ready buffer between the converter and its reader
`timescale 1ns/100ps
module aacc_buf #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
) (
   input wire logic clk, // main clock
   input wire logic nrstSync, // synchronised reset, active low
   input wire logic inValid, // write request
   output logic inReady, // room for one more word
   input wire logic [WIDTH-1:0] inData, // word to store
   output logic outValid, // a word is waiting
   input wire logic outReady, // reader takes the word
   output logic [WIDTH-1:0] outData, // oldest word
   output logic [$clog2(DEPTH):0] level // words held
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_r;
   logic [PW-1:0] rdPtr_r;
   logic [PW:0] count_r;
   logic doWr;
   logic doRd;

   assign inReady = (count_r < (PW+1)'(DEPTH));
   assign outValid = (count_r != '0);
   assign outData = mem[rdPtr_r];
   assign level = count_r;
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;

   always_ff @(posedge clk) begin
      if (doWr)
         mem[wrPtr_r] <= inData;
   end

   always_ff @(posedge clk or negedge nrstSync) begin
      if (!nrstSync) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else begin
         if (doWr)
            wrPtr_r <= wrPtr_r + 1'b1;
         if (doRd)
            rdPtr_r <= rdPtr_r + 1'b1;
         count_r <= count_r + (PW+1)'(doWr) - (PW+1)'(doRd);
      end
   end
endmodule

// >>> verif/aacc_mod_model.sv
// behavioural modulator source driving the aux bitstream pin
`timescale 1ns/100ps
module aacc_mod_model (
   input wire logic modClk, // modulator clock from the block
   input wire logic high, // 1 gives all plus, 0 all minus
   output logic bitOut // bitstream pin
);
   // one bit per modulator period, level follows the setting
   always @(posedge modClk or high) begin
      bitOut <= high;
   end
endmodule

// >>> verif/aacc_monitor.sv
// concurrent checks on the ports of the aux converter control top
`timescale 1ns/100ps
module aacc_monitor
   import aacc_pkg::*;
(
   input wire logic clk, // main clock
   input wire logic nrst, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pready, // apb ready
   input wire logic stepStart, // step start
   input wire aacc_pkg::aacc_step_t stepCfg, // step selects
   input wire logic stepReady, // step may start
   input wire logic modClkOut, // modulator clock
   input wire aacc_pkg::aacc_route_t route, // mux setting
   input wire logic resultStrobe, // result done
   input wire logic curValid, // current words in
   input wire aacc_pkg::aacc_cur_t curRaw, // raw current words
   input wire logic [23:0] curCodeA, // code a
   input wire logic [23:0] curCodeB, // code b
   input wire logic curCodeValid // codes updated
);
   logic [1:0] osrW_r;
   logic [1:0] osrL_r;
   logic [11:0] cnt_r;
   logic busy_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   function automatic logic [11:0] expCyc(input logic [1:0] o);
      return (12'h002 + (12'h001 << o)) * 12'h080 + 12'h001;
   endfunction
   function automatic logic [23:0] satC(input logic signed [31:0] v);
      if (v > 32'sh007F_FFFF) return 24'h7F_FFFF;
      if (v < 32'shFF80_0000) return 24'h80_0000;
      return v[23:0];
   endfunction
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) osrW_r <= 2'h0;
      else if (psel && penable && pwrite && pready && paddr == REG_CTRL)
         osrW_r <= pwdata[1:0];
   end
   // track the conversion in flight and its elapsed cycles
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         cnt_r <= 12'h000;
         osrL_r <= 2'h0;
      end else if (stepStart && stepReady) begin
         busy_r <= 1'b1;
         cnt_r <= 12'h000;
         osrL_r <= osrW_r;
      end else if (resultStrobe) busy_r <= 1'b0;
      else if (busy_r) cnt_r <= cnt_r + 12'h001;
   end
   sequence stepTaken;
      stepStart && stepReady;
   endsequence
   sequence quietRun;
      (!stepReady && !resultStrobe) [*8];
   endsequence
   conv_time_a: assert property (
      resultStrobe |-> busy_r && cnt_r == expCyc(osrL_r))
      else $error("result strobe at wrong cycle count");
   single_shot_a: assert property (stepTaken |=> quietRun)
      else $error("step accepted or result given while converting");
   strobe_pulse_a: assert property (resultStrobe |=> !resultStrobe)
      else $error("result strobe longer than one cycle");
   route_cfg_a: assert property (stepTaken |=>
      route.gain == ($past(stepCfg.gainSel) == 2'h3 ? GAIN_X1 :
      $past(stepCfg.gainSel)) && ($past(stepCfg.posSel) == POS_EXT_LAST
      || route.pos == $past(stepCfg.posSel)))
      else $error("route does not follow step selects");
   internal_src_a: assert property (
      route.pos > POS_EXT_LAST |-> !route.extConnect && !route.negIn7)
      else $error("internal source left inputs connected");
   neg_input_a: assert property (
      route.negIn7 |-> route.pos < POS_EXT_LAST && route.extConnect)
      else $error("eighth input negative with bad positive");
   mod_toggle_a: assert property (
      busy_r && cnt_r > 12'h002 && cnt_r < 12'h12C
      |-> modClkOut != $past(modClkOut))
      else $error("modulator clock not at half rate");
   mod_idle_a: assert property (!busy_r [*4] |-> !modClkOut)
      else $error("modulator clock runs while idle");
   cur_sat_a: assert property (curValid |=> curCodeValid &&
      curCodeA == satC($past(curRaw.rawA)) &&
      curCodeB == satC($past(curRaw.rawB)))
      else $error("current code not clipped two's complement");
endmodule
bind aacc_top aacc_monitor u_mon (.clk, .nrst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .stepStart, .stepCfg, .stepReady, .modClkOut,
   .route, .resultStrobe, .curValid, .curRaw, .curCodeA, .curCodeB,
   .curCodeValid);

// >>> verif/tb_aacc_top.sv
// self-checking bench for the aux converter control top
`timescale 1ns/100ps
module tb_aacc_top;
   import aacc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, q;
   logic pready, pslverr, stepReady, modBitPin, modClkOut, e;
   logic stepStart = 1'b0;
   logic resReady = 1'b1;
   logic curValid = 1'b0;
   logic modHigh = 1'b0;
   logic resultStrobe, resValid, curCodeValid;
   logic [15:0] resData;
   logic [23:0] curCodeA, curCodeB;
   aacc_step_t stepCfg = '0;
   aacc_step_t c;
   aacc_route_t route;
   aacc_cur_t curRaw = '0;
   logic signed [31:0] ra, rb;
   int errCount = 0;
   int cmpCount = 0;
   aacc_top u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stepStart(stepStart),
      .stepCfg(stepCfg), .stepReady(stepReady), .modBitPin(modBitPin),
      .modClkOut(modClkOut), .route(route), .resultStrobe(resultStrobe),
      .resData(resData), .resValid(resValid), .resReady(resReady),
      .curValid(curValid), .curRaw(curRaw), .curCodeA(curCodeA),
      .curCodeB(curCodeB), .curCodeValid(curCodeValid));
   aacc_mod_model u_mod (.modClk(modClkOut), .high(modHigh),
      .bitOut(modBitPin));
   always #10 clk = ~clk;
   function automatic logic [23:0] sat(input logic signed [31:0] v);
      if (v > 32'sh007F_FFFF) return 24'h7F_FFFF;
      if (v < 32'shFF80_0000) return 24'h80_0000;
      return v[23:0];
   endfunction
   task automatic chk(input logic [31:0] got, exp, input string msg);
      cmpCount++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmpCount, errCount);
      if (errCount == 0 && cmpCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one step; pop checks the result and the result register
   task automatic run_step(input aacc_step_t s, input logic [1:0] osr,
      input logic uni, hi, pop);
      int n;
      logic [15:0] x;
      logic ext;
      modHigh <= hi;
      apb(1'b1, REG_CTRL, {29'h0000_0000, uni, osr});
      do begin
         @(negedge clk);
      end while (stepReady !== 1'b1);
      @(posedge clk);
      stepCfg <= s;
      stepStart <= 1'b1;
      @(posedge clk);
      stepStart <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         @(negedge clk);
      end while (resultStrobe !== 1'b1);
      chk(n, (32'h0000_0002 + (32'h0000_0001 << osr)) * 32'h0000_0080 + 1,
         "conversion time");
      ext = s.posSel <= POS_EXT_LAST;
      chk(route.extConnect, ext && !(s.negSel && s.posSel == POS_EXT_LAST),
         "ext connect");
      chk(route.negIn7, ext && s.negSel && s.posSel != POS_EXT_LAST,
         "negative select");
      chk(route.gain, s.gainSel == 2'h3 ? GAIN_X1 : s.gainSel, "gain");
      if (!(s.negSel && s.posSel == POS_EXT_LAST))
         chk(route.pos, s.posSel, "positive select");
      chk(route.err, (s.negSel && s.posSel == POS_EXT_LAST) ||
         s.gainSel == 2'h3, "config error");
      x = hi ? 16'h7FFF : (uni ? 16'h0000 : 16'h8000);
      if (pop) begin
         // the word reaches the buffer output one cycle after the strobe
         @(negedge clk);
         chk({resValid, resData}, {1'b1, x}, "result word");
         apb(1'b0, REG_RESULT, 32'h0000_0000);
         chk(q[15:0], x, "result register");
      end
   endtask
   initial begin
      #(60000 * 20);
      errCount++;
      $display("watchdog expired");
      close_out();
   end
   initial begin
      void'($urandom(32'h6d01be4b));
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      apb(1'b0, REG_CTRL, 32'h0000_0000);
      chk(q, {29'h0, CTRL_UNIPOLAR_RST, CTRL_OSR_RST}, "ctrl reset");
      apb(1'b1, 12'h014, 32'hFFFF_FFFF);
      chk(e, 1'b1, "unmapped write error");
      apb(1'b0, 12'h014, 32'h0000_0000);
      chk(e, 1'b1, "unmapped read error");
      chk(q, 32'h0000_0000, "unmapped read data");
      $display("test registers done");
      // offset calibration uses the internal ground short
      run_step({POS_SHORT, NEG_IN7, GAIN_X4}, 2'h0, 1'b0, 1'b1, 1'b1);
      for (int i = 0; i < 16; i++) begin
         c = 7'($urandom);
         c.posSel = i[3:0];
         c.gainSel = i[3:2];
         // eighth input as negative, with and without the clash
         if (i[3:1] == 3'h3)
            c.negSel = NEG_IN7;
         run_step(c, i[1:0], 1'($urandom), 1'($urandom), 1'b1);
      end
      $display("test step sweep done");
      resReady <= 1'b0;
      run_step(c, 2'h1, 1'b0, 1'b1, 1'b0);
      run_step(c, 2'h0, 1'b0, 1'b0, 1'b0);
      @(negedge clk);
      chk(stepReady, 1'b0, "full buffer blocks steps");
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      chk(q[5:4], 2'h2, "buffer level");
      @(posedge clk);
      resReady <= 1'b1;
      @(negedge clk);
      chk(resData, 16'h7FFF, "first buffered");
      @(negedge clk);
      chk(resData, 16'h8000, "second buffered");
      @(negedge clk);
      chk(resValid, 1'b0, "buffer drained");
      $display("test buffer done");
      for (int i = 0; i < 12; i++) begin
         ra = $signed($urandom) >>> ($urandom % 12);
         // hand-picked codes around zero and at both clipping limits
         if (i < 4)
            ra = 32'sd1 - i;
         rb = i < 2 ? 32'sh0080_0000 - i :
            (i < 4 ? i - 32'sh0080_0003 : -ra);
         @(posedge clk);
         curRaw <= {ra, rb};
         curValid <= 1'b1;
         @(posedge clk);
         curValid <= 1'b0;
         @(negedge clk);
         chk(curCodeValid, 1'b1, "current valid");
         chk({curCodeA, curCodeB}, {sat(ra), sat(rb)}, "codes");
      end
      apb(1'b0, REG_CUR_B, 32'h0000_0000);
      chk(q[23:0], sat(rb), "current register");
      $display("test current codes done");
      close_out();
   end
endmodule
